/* dic_ctl.v */
// DAC input interface control: level decode, data clock, whitening, parity, scan, APB.
// Operation
// (RQ1) Drive data clock at quarter update rate.
// (RQ2) Source divides clock when internal divider off.
// (RQ3) Decode both selects as four-level inputs.
// (RQ4) Bypass high, band high: DLL off, delayed.
// (RQ5) Bypass high, band low: DLL off, undelayed.
// (RQ6) Bypass low: band high or open ranges.
// (RQ7) Bypass open: three DLL ranges by band.
// (RQ8) Bypass resistor: three lowest DLL ranges.
// (RQ9) Controller resets DLL on every band change; the code takes a new band code only while bypass is high.
// (RQ10) Controller resets DLL after power and clock.
// (RQ11) Parity is one for odd ones count.
// (RQ12) Mismatch raises fail flag for 48 words.
// (RQ13) Source XORs check bit with whitening.
// (RQ14) Source delays whitening one, check three.
// (RQ15) Modulation input inverts channels B and D.
// (RQ16) Scan low: status pin shows DLL lock.
// (RQ17) Scan high: input registers shift out serially.
// (RQ18) Source loads known data before raising scan.
// (RQ19) Shift order: sync, gap, lanes, check, whitening.
// (RQ20) Extra scan bits undefined; scan low restores lock.
// (RQ21) Run sample clock slower during scan.
// (RQ22) Reference low halts clocking and clock drive.
// (RQ23) Whitening lane XORs all four channel words.
// (RQ24) Source drives toggling sync lane for DLL.
// (RQ25) Halve sample clock, then delay and divide.
// (RQ26) Parity over aligned lanes versus received check.
// (RQ27) Select codes sampled, held except in DLL reset.
//
// Local design decisions: register access over APB and the register addresses.
`timescale 1ns/1ps
`include "dic_map.vh"
module dic_ctl (
  input wire clk_sys, // Sample clock stand-in, 10 MHz.
  input wire rst_n, // Synchronous reset, active low.
  input wire [1:0] loop_bypass_sel, // Four-level bypass pin as a two-bit code.
  input wire [1:0] band_sel, // Four-level band pin as a two-bit code.
  input wire [13:0] lane_a_in, // Channel A word.
  input wire [13:0] lane_b_in, // Channel B word.
  input wire [13:0] lane_c_in, // Channel C word.
  input wire [13:0] lane_d_in, // Channel D word.
  input wire loop_reference_in, // Toggling sync lane.
  input wire whiten_lane, // Whitening lane.
  input wire check_bit_lane, // Received check bit lane.
  input wire half_rate_invert_in, // Modulation input, pulled down outside.
  input wire scan_enable, // Scan mode select.
  input wire ref_low_in, // Reference node below protection level.
  input wire psel, // APB select.
  input wire penable, // APB enable.
  input wire pwrite, // APB direction.
  input wire [11:0] paddr, // APB byte address.
  input wire [31:0] pwdata, // APB write data.
  output reg [31:0] prdata, // APB read data.
  output reg pready, // APB ready.
  output reg pslverr, // APB error on unmapped address.
  output reg source_word_clock, // Data clock to the source.
  output reg source_word_clock_oe, // High while the data clock is driven.
  output reg status_out, // Dual lock / scan output.
  output reg check_fail_flag, // Parity failure, held 48 words.
  output reg [13:0] lane_a_out, // Descrambled channel A.
  output reg [13:0] lane_b_out, // Descrambled channel B.
  output reg [13:0] lane_c_out, // Descrambled channel C.
  output reg [13:0] lane_d_out, // Descrambled channel D.
  output reg sample_valid // One-cycle pulse with each new output word.
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers.
  wire [13:0] a_s, b_s, c_s, d_s; // Synchronised lanes.
  wire [1:0] byp_s, band_s; // Synchronised select codes.
  wire ref_s, wht_s, chk_s, inv_s, scan_s, low_s; // Synchronised single pins.

  // Every pin but reset and the APB bus crosses two flip-flops; the lanes share one delay so they stay aligned.
  dic_sync2 #(.WIDTH(66)) u_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .async_in({lane_a_in, lane_b_in, lane_c_in, lane_d_in, loop_bypass_sel, band_sel,
               loop_reference_in, whiten_lane, check_bit_lane, half_rate_invert_in,
               scan_enable, ref_low_in}),
    .sync_out({a_s, b_s, c_s, d_s, byp_s, band_s, ref_s, wht_s, chk_s, inv_s, scan_s, low_s})
  );

  ////////////////////////////////////////////////////////////////////////////
  // Four-level select sampling and decode.
  reg [1:0] byp_q; // Held bypass code.
  reg [1:0] band_q; // Held band code.
  reg dll_en; // DLL enabled.
  reg delay_add; // Extra period on the data clock.
  reg [3:0] band_idx; // Range index, 1 fastest, 0 none.
  wire dll_reset = (byp_q == `DIC_LVL_HIGH); // Bypass high holds the DLL in reset.

  // Codes load only while the DLL is in reset or the bypass pin reads high, so a glitch on the band pin cannot retune a locked loop.
  always @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      byp_q <= `DIC_LVL_HIGH;
      band_q <= `DIC_LVL_LOW;
    end
    else if (dll_reset || byp_s == `DIC_LVL_HIGH) // [RQ27]
    begin
      byp_q <= byp_s;
      band_q <= band_s;
    end
  end

  // Table decode of the two held codes; combinations outside the table leave the DLL off.
  always @*
  begin
    dll_en = 1'b0;
    delay_add = 1'b0;
    band_idx = 4'h0;
    case (byp_q) // [RQ3]
      `DIC_LVL_HIGH:
      begin
        delay_add = (band_q == `DIC_LVL_HIGH); // [RQ4] [RQ5]
      end
      `DIC_LVL_LOW:
      begin
        if (band_q == `DIC_LVL_HIGH) band_idx = 4'h1; // [RQ6]
        else if (band_q == `DIC_LVL_OPEN) band_idx = 4'h2; // [RQ6]
      end
      `DIC_LVL_OPEN:
      begin
        if (band_q == `DIC_LVL_LOW) band_idx = 4'h3; // [RQ7]
        else if (band_q == `DIC_LVL_HIGH) band_idx = 4'h4; // [RQ7]
        else if (band_q == `DIC_LVL_OPEN) band_idx = 4'h5; // [RQ7]
      end
      default:
      begin
        if (band_q == `DIC_LVL_LOW) band_idx = 4'h6; // [RQ8]
        else if (band_q == `DIC_LVL_HIGH) band_idx = 4'h7; // [RQ8]
        else if (band_q == `DIC_LVL_OPEN) band_idx = 4'h8; // [RQ8]
      end
    endcase
    dll_en = (band_idx != 4'h0);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data-rate enable and data clock output.
  reg phase_q; // Half-rate phase of the sample clock.
  reg phase_dly_q; // Phase delayed by one sample period.
  reg div_q; // Optional further divide by two.
  reg [31:0] ctrl_q; // Control register.
  wire halt = low_s; // Protection detector active.
  wire word_en = phase_q & ~halt; // One pulse per data word.

  // The sample clock is halved to the word rate, then delayed one sample when delay_add is set, or instead halved again when DIV2 is set.
  always @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      phase_q <= 1'b0;
      phase_dly_q <= 1'b0;
      div_q <= 1'b0;
      source_word_clock <= 1'b0;
      source_word_clock_oe <= 1'b0;
    end
    else if (halt) // [RQ22]
    begin
      phase_q <= 1'b0;
      phase_dly_q <= 1'b0;
      source_word_clock <= 1'b0;
      source_word_clock_oe <= 1'b0;
    end
    else
    begin
      phase_q <= ~phase_q; // [RQ25]
      phase_dly_q <= phase_q;
      if (word_en)
        div_q <= ~div_q;
      source_word_clock_oe <= 1'b1;
      if (ctrl_q[`DIC_CTRL_DIV2]) // [RQ25]
        source_word_clock <= div_q;
      else if (delay_add) // [RQ4]
        source_word_clock <= phase_dly_q;
      else
        source_word_clock <= phase_q; // [RQ1]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // DLL lock model.
  reg ref_prev_q; // Sync lane value at the previous word.
  reg [7:0] lock_cnt_q; // Sync toggles seen since the reset.
  wire locked = (lock_cnt_q == `DIC_LOCK_TOGGLES); // Lock reached.

  // The loop closes on toggles of the sync lane; a reset or halt drops the lock.
  always @(posedge clk_sys)
  begin
    if (!rst_n || dll_reset || !dll_en || halt)
    begin
      lock_cnt_q <= 8'h00;
      ref_prev_q <= 1'b0;
    end
    else if (word_en)
    begin
      ref_prev_q <= ref_s;
      if (ref_s != ref_prev_q && !locked)
        lock_cnt_q <= lock_cnt_q + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input register, whitening and modulation.
  reg [55:0] in_q; // Input register {D, C, B, A}.
  reg sync_q; // Captured sync lane.
  reg par1_q, par2_q; // Computed parity in flight to the check bit.
  reg [5:0] fail_cnt_q; // Words left on the fail flag.
  reg [8:0] scan_pos_q; // Bit position in the scan stream.
  reg [`DIC_SCAN_LEN-1:0] scan_q; // Scan shift chain.
  reg scan_prev_q; // Scan enable at the previous cycle.
  wire [13:0] wmask = {14{wht_s}}; // Whitening arrives one word behind its data.
  wire par_calc = ^(in_q ^ {4{wmask}}) ^ wht_s; // [RQ11] [RQ26]

  // Capture on every word unless scanning; output words follow one word later.
  always @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      in_q <= 56'h00_0000_0000_0000;
      sync_q <= 1'b0;
      lane_a_out <= 14'h0000;
      lane_b_out <= 14'h0000;
      lane_c_out <= 14'h0000;
      lane_d_out <= 14'h0000;
      sample_valid <= 1'b0;
      par1_q <= 1'b0;
      par2_q <= 1'b0;
    end
    else
    begin
      sample_valid <= word_en && !scan_s;
      if (word_en && !scan_s)
      begin
        in_q <= {d_s, c_s, b_s, a_s};
        sync_q <= ref_s;
        lane_a_out <= in_q[13:0] ^ wmask; // [RQ23]
        lane_c_out <= in_q[41:28] ^ wmask; // [RQ23]
        lane_b_out <= in_q[27:14] ^ wmask ^ {14{inv_s}}; // [RQ15]
        lane_d_out <= in_q[55:42] ^ wmask ^ {14{inv_s}}; // [RQ15]
        par1_q <= par_calc;
        par2_q <= par1_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Check-fail flag.
  // A new mismatch reloads the hold count, so the flag never drops during an error burst.
  always @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      fail_cnt_q <= 6'h00;
      check_fail_flag <= 1'b0;
    end
    else
    begin
      if (word_en && !scan_s && chk_s != par2_q) // [RQ12]
        fail_cnt_q <= `DIC_FAIL_HOLD;
      else if (word_en && fail_cnt_q != 6'h00)
        fail_cnt_q <= fail_cnt_q - 6'h01;
      check_fail_flag <= (fail_cnt_q != 6'h00); // [RQ12]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Scan chain and dual status output.
  // On scan start the chain freezes the input register; then one bit leaves per word.
  always @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      scan_prev_q <= 1'b0;
      scan_pos_q <= 9'h000;
      scan_q <= {`DIC_SCAN_LEN{1'b0}};
      status_out <= 1'b0;
    end
    else
    begin
      scan_prev_q <= scan_s;
      if (scan_s && !scan_prev_q) // [RQ17]
      begin
        scan_pos_q <= 9'h000;
        scan_q <= {in_q[42], in_q[43], in_q[44], in_q[45], in_q[46], in_q[47], in_q[48],
                   in_q[49], in_q[50], in_q[51], in_q[52], in_q[53], in_q[54], in_q[55],
                   in_q[28], in_q[29], in_q[30], in_q[31], in_q[32], in_q[33], in_q[34],
                   in_q[35], in_q[36], in_q[37], in_q[38], in_q[39], in_q[40], in_q[41],
                   in_q[14], in_q[15], in_q[16], in_q[17], in_q[18], in_q[19], in_q[20],
                   in_q[21], in_q[22], in_q[23], in_q[24], in_q[25], in_q[26], in_q[27],
                   in_q[0], in_q[1], in_q[2], in_q[3], in_q[4], in_q[5], in_q[6],
                   in_q[7], in_q[8], in_q[9], in_q[10], in_q[11], in_q[12], in_q[13],
                   par1_q, wht_s}; // [RQ19]
        status_out <= sync_q; // [RQ19]
      end
      else if (scan_s)
      begin
        if (word_en) // [RQ19]
        begin
          if (scan_pos_q != 9'h1FF)
            scan_pos_q <= scan_pos_q + 9'h001;
          if (scan_pos_q < `DIC_SCAN_GAP_END)
            status_out <= 1'b0; // Undefined gap bits read as zero.
          else if (scan_pos_q <= `DIC_SCAN_LAST)
          begin
            status_out <= scan_q[`DIC_SCAN_LEN-1];
            scan_q <= {scan_q[`DIC_SCAN_LEN-2:0], 1'b0};
          end
          else
            status_out <= 1'b0; // [RQ20]
        end
      end
      else
        status_out <= locked; // [RQ16] [RQ20]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave.
  reg [31:0] errcnt_q; // Parity mismatches seen, write clears.
  wire access = psel && penable && pready; // Completing access edge.
  wire hit_ctrl = (paddr == `DIC_OFS_CTRL);
  wire hit_stat = (paddr == `DIC_OFS_STATUS);
  wire hit_err = (paddr == `DIC_OFS_ERRCNT);
  wire new_err = word_en && !scan_s && (chk_s != par2_q);
  wire [31:0] status_word = {16'h0000, band_s, byp_q, band_idx, 2'h0, halt, scan_s,
                             check_fail_flag, delay_add, dll_en, locked};

  // One wait state: ready rises at the edge that ends the first access cycle and the answer lands with it.
  always @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      ctrl_q <= `DIC_CTRL_RST;
      errcnt_q <= 32'h0000_0000;
    end
    else
    begin
      pready <= psel && penable && !pready;
      if (psel && penable && !pready)
      begin
        pslverr <= !(hit_ctrl || hit_stat || hit_err);
        if (hit_ctrl)
          prdata <= ctrl_q;
        else if (hit_stat)
          prdata <= status_word;
        else if (hit_err)
          prdata <= errcnt_q;
        else
          prdata <= 32'h0000_0000;
      end
      if (access && pwrite && hit_ctrl)
        ctrl_q <= {31'h0000_0000, pwdata[`DIC_CTRL_DIV2]};
      // A mismatch in the clearing cycle survives as a count of one.
      if (access && pwrite && hit_err)
        errcnt_q <= new_err ? 32'h0000_0001 : 32'h0000_0000;
      else if (new_err && errcnt_q != 32'hFFFF_FFFF)
        errcnt_q <= errcnt_q + 32'h0000_0001;
    end
  end

endmodule // dic_ctl

/* dic_ctl_properties.sv */
// Concurrent checks on the ports of the DAC input interface control block.
`timescale 1ns/1ps
module dic_ctl_properties (
  input logic clk_sys, // System clock.
  input logic rst_n, // Synchronous reset, active low.
  input logic psel, // APB select.
  input logic penable, // APB enable.
  input logic [11:0] paddr, // APB byte address.
  input logic pready, // APB ready.
  input logic pslverr, // APB error.
  input logic [31:0] prdata, // APB read data.
  input logic ref_low_in, // Reference low.
  input logic scan_enable, // Scan select.
  input logic source_word_clock_oe, // Data clock drive.
  input logic sample_valid, // Word strobe.
  input logic check_fail_flag // Parity failure flag.
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////
  // Counts consecutive high cycles of the flag; saturates so it never wraps to a short value.
  logic [7:0] hi_cnt_q;
  always @(posedge clk_sys)
  begin
    if (!rst_n || !check_fail_flag)
      hi_cnt_q <= 8'h00;
    else if (hi_cnt_q != 8'hFF)
      hi_cnt_q <= hi_cnt_q + 8'h01;
  end
  ////////////////////////////////////////////////////////////////
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable;
  endsequence
  sequence s_halt;
    ref_low_in [*4];
  endsequence
  chk_ready_wait: assert property (s_setup ##1 s_access |=> pready)
    else $error("ready late after access");
  chk_no_early: assert property (s_setup |-> !pready)
    else $error("ready during setup");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  chk_err_map: assert property (pready && paddr != 12'h000 && paddr != 12'h004
    && paddr != 12'h008 |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  chk_fail_hold: assert property ($fell(check_fail_flag) |-> hi_cnt_q >= 8'h5F)
    else $error("fail flag dropped early");
  chk_halt_oe: assert property (s_halt |-> !source_word_clock_oe)
    else $error("data clock driven while halted");
  chk_halt_word: assert property (ref_low_in [*6] |-> !sample_valid)
    else $error("word taken while halted");
  chk_run_oe: assert property (!ref_low_in [*6] |-> source_word_clock_oe)
    else $error("data clock not driven");
  chk_scan_hold: assert property (scan_enable [*8] |-> !sample_valid)
    else $error("word taken during scan");
  chk_word_rate: assert property (sample_valid |=> !sample_valid)
    else $error("words faster than half rate");
endmodule // dic_ctl_properties

bind dic_ctl dic_ctl_properties dic_ctl_properties_i (.clk_sys, .rst_n, .psel, .penable,
  .paddr, .pready, .pslverr, .prdata, .ref_low_in, .scan_enable, .source_word_clock_oe,
  .sample_valid, .check_fail_flag);

/* dic_ctl_tb_top.sv */
// Self-checking testbench of the DAC input interface control block.
`timescale 1ns/1ps
`include "dic_map.vh"
module dic_ctl_tb_top;
  localparam logic [15:0] BYP_T = 16'hFEA0; // Bypass codes of the eight DLL bands.
  localparam logic [15:0] BAND_T = 16'h9249; // Band codes of the eight DLL bands.
  logic clk_sys = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [1:0] loop_bypass_sel = 2'h1, band_sel = 2'h0;
  logic half_rate_invert_in = 1'b0, scan_enable = 1'b0, ref_low_in = 1'b0;
  logic white = 1'b0, corrupt = 1'b0, er, found, ok;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rd;
  logic [55:0] word = 56'h0;
  logic [0:599] s;
  integer mismatches = 0, comparisons = 0, i, j, o;
  wire [13:0] lane_a_in, lane_b_in, lane_c_in, lane_d_in;
  wire [13:0] lane_a_out, lane_b_out, lane_c_out, lane_d_out;
  wire [31:0] prdata;
  wire loop_reference_in, whiten_lane, check_bit_lane, pready, pslverr, source_word_clock;
  wire source_word_clock_oe, status_out, check_fail_flag, sample_valid;
  always #50 clk_sys = ~clk_sys;
  ////////////////////////////////////////////////////////////////
  dic_ctl dic_ctl_i (.clk_sys, .rst_n, .loop_bypass_sel, .band_sel, .lane_a_in, .lane_b_in,
    .lane_c_in, .lane_d_in, .loop_reference_in, .whiten_lane, .check_bit_lane,
    .half_rate_invert_in, .scan_enable, .ref_low_in, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .source_word_clock, .source_word_clock_oe,
    .status_out, .check_fail_flag, .lane_a_out, .lane_b_out, .lane_c_out, .lane_d_out,
    .sample_valid);
  // An undriven clock line shows no edges to the source.
  dic_src_model dic_src_model_i (.clk_sys, .rst_n,
    .source_word_clock(source_word_clock & source_word_clock_oe), .word_in(word),
    .white_in(white), .corrupt_in(corrupt),
    .lanes_out({lane_d_in, lane_c_in, lane_b_in, lane_a_in}), .loop_reference_in,
    .whiten_lane, .check_bit_lane);
  ////////////////////////////////////////////////////////////////
  task print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons = comparisons + 1;
    if (seen !== exp)
    begin
      mismatches = mismatches + 1;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task wt(input integer n);
    repeat (n) @(posedge clk_sys);
  endtask
  // One APB transfer; the request stands until pready is seen high at an edge.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    integer n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1 && n < 20)
    begin
      n = n + 1;
      @(posedge clk_sys);
    end
    if (n == 20)
    begin
      mismatches = mismatches + 1;
      print_verdict();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // One idle edge, so a following call never lowers and raises psel in one time step.
    @(posedge clk_sys);
  endtask
  // Counts rising edges of the data clock over forty sampled edges.
  task edges(output integer c);
    logic p;
    c = 0;
    @(posedge clk_sys);
    p = source_word_clock;
    repeat (40)
    begin
      @(posedge clk_sys);
      if (source_word_clock && !p)
        c = c + 1;
      p = source_word_clock;
    end
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    wt(6);
    rst_n <= 1'b1;
    wt(2);
    apb(1'b0, `DIC_OFS_CTRL, 32'h0);
    chk(rd, `DIC_CTRL_RST);
    apb(1'b1, `DIC_OFS_CTRL, 32'h1);
    edges(o);
    chk(o, 10);
    apb(1'b0, `DIC_OFS_CTRL, 32'h0);
    chk(rd, 32'h1);
    apb(1'b1, `DIC_OFS_CTRL, 32'h0);
    edges(o);
    chk(o, 20);
    apb(1'b0, 12'h00C, 32'h0);
    chk({rd[30:0], er}, 32'h1);
    band_sel <= `DIC_LVL_HIGH;
    wt(10);
    apb(1'b0, `DIC_OFS_STATUS, 32'h0);
    chk(rd[2:1], 2'h2);
    chk(status_out, 1'b0);
    band_sel <= `DIC_LVL_LOW;
    wt(10);
    apb(1'b0, `DIC_OFS_STATUS, 32'h0);
    chk(rd[2:1], 2'h0);
    // Each band is entered through a DLL reset with bypass high.
    for (i = 0; i < 8; i = i + 1)
    begin
      loop_bypass_sel <= `DIC_LVL_HIGH;
      band_sel <= BAND_T[2*i+:2];
      wt(8);
      loop_bypass_sel <= BYP_T[2*i+:2];
      wt(60);
      apb(1'b0, `DIC_OFS_STATUS, 32'h0);
      chk({rd[13:8], rd[1:0]}, {BYP_T[2*i+:2], i[3:0] + 4'h1, 2'h3});
    end
    chk(status_out, 1'b1);
    word <= {14'h3001, 14'h0F0F, 14'h2ABC, 14'h1234};
    white <= 1'b1;
    wt(10);
    apb(1'b1, `DIC_OFS_ERRCNT, 32'h0);
    wt(20);
    apb(1'b0, `DIC_OFS_ERRCNT, 32'h0);
    chk(rd, 32'h0);
    chk(lane_a_out, 14'h1234 ^ 14'h3FFF);
    chk(lane_b_out, 14'h2ABC ^ 14'h3FFF);
    half_rate_invert_in <= 1'b1;
    wt(10);
    chk(lane_b_out, 14'h2ABC);
    chk(lane_d_out, 14'h3001);
    chk(lane_c_out, 14'h0F0F ^ 14'h3FFF);
    half_rate_invert_in <= 1'b0;
    corrupt <= 1'b1;
    wt(2);
    corrupt <= 1'b0;
    wt(10);
    chk(check_fail_flag, 1'b1);
    apb(1'b0, `DIC_OFS_ERRCNT, 32'h0);
    chk(rd, 32'h1);
    wt(75);
    chk(check_fail_flag, 1'b1);
    wt(30);
    chk(check_fail_flag, 1'b0);
    apb(1'b1, `DIC_OFS_ERRCNT, 32'h0);
    apb(1'b0, `DIC_OFS_ERRCNT, 32'h0);
    chk(rd, 32'h0);
    white <= 1'b0;
    wt(10); // Known data settles before scan rises.
    // The bench clock already runs far below the sample rate, as the slow scan pins need.
    scan_enable <= 1'b1;
    for (i = 0; i < 600; i = i + 1)
    begin
      @(posedge clk_sys);
      s[i] = status_out;
    end
    // The lane bits, each held one word, follow the gap somewhere in this span.
    found = 1'b0;
    for (o = 300; o < 460; o = o + 1)
    begin
      ok = 1'b1;
      for (j = 0; j < 56; j = j + 1)
        if (s[o + 2 * j] !== word[(3 - j / 14) * 14 + j % 14])
          ok = 1'b0;
      if (ok)
        found = 1'b1;
    end
    chk(found, 1'b1);
    scan_enable <= 1'b0;
    wt(10);
    chk(status_out, 1'b1);
    ref_low_in <= 1'b1;
    wt(10);
    chk(source_word_clock_oe, 1'b0);
    ref_low_in <= 1'b0;
    wt(10);
    chk(source_word_clock_oe, 1'b1);
    print_verdict();
  end
endmodule // dic_ctl_tb_top

/* dic_map.vh */
// Constants of the DAC input interface control block: offsets, fields, resets, counts.
`ifndef DIC_MAP_VH
`define DIC_MAP_VH

// Register byte offsets on the APB slave.
`define DIC_OFS_CTRL 12'h000
`define DIC_OFS_STATUS 12'h004
`define DIC_OFS_ERRCNT 12'h008

// Control register fields and reset value.
`define DIC_CTRL_DIV2 0
`define DIC_CTRL_RST 32'h0000_0000

// Status register fields.
`define DIC_ST_LOCK 0
`define DIC_ST_DLLEN 1
`define DIC_ST_DELAY 2
`define DIC_ST_FAIL 3
`define DIC_ST_SCAN 4
`define DIC_ST_HALT 5
`define DIC_ST_BAND_LO 8
`define DIC_ST_BAND_HI 11
`define DIC_ST_BYP_LO 12
`define DIC_ST_BYP_HI 13
`define DIC_ST_SEL_LO 14
`define DIC_ST_SEL_HI 15

// Four-level pin codes.
`define DIC_LVL_LOW 2'h0
`define DIC_LVL_HIGH 2'h1
`define DIC_LVL_OPEN 2'h2
`define DIC_LVL_RGND 2'h3

// Timing counts, in data-rate words.
`define DIC_FAIL_HOLD 6'h30
`define DIC_LOCK_TOGGLES 8'h10

// Scan stream layout, in bit positions after the scan start.
`define DIC_SCAN_GAP_END 9'h0B3
`define DIC_SCAN_LAST 9'h0ED
`define DIC_SCAN_LEN 58

`endif

/* dic_src_model.sv */
// Sample data source model clocked by the block's data clock.
`timescale 1ns/1ps
module dic_src_model (
  input logic clk_sys, // System clock used to sample the data clock.
  input logic rst_n, // Synchronous reset, active low.
  input logic source_word_clock, // Data clock, gated by its drive enable.
  input logic [55:0] word_in, // Next words, D in the top lane.
  input logic white_in, // Whitening value for the word.
  input logic corrupt_in, // Flips the check bit sent at that word.
  output logic [55:0] lanes_out = 56'h0, // Lane data.
  output logic loop_reference_in = 1'b0, // Toggling sync lane.
  output logic whiten_lane = 1'b0, // Whitening lane.
  output logic check_bit_lane = 1'b0 // Check bit lane.
);
  logic clk_prev = 1'b0;
  logic white_q = 1'b0;
  logic [2:0] par_q = 3'h0;
  ////////////////////////////////////////////////////////////////
  // One word per rising data-clock edge; a stopped clock freezes the stream.
  // With the internal halving off, the model still sends one word per rising edge and does not divide the clock itself.
  always @(posedge clk_sys)
  begin
    clk_prev <= source_word_clock;
    if (!rst_n)
      par_q <= 3'h0;
    else if (source_word_clock && !clk_prev)
    begin
      lanes_out <= word_in;
      loop_reference_in <= !loop_reference_in;
      white_q <= white_in;
      whiten_lane <= white_q; // One word behind its data.
      par_q <= {par_q[1:0], ^word_in ^ white_in};
      check_bit_lane <= par_q[2] ^ corrupt_in; // Three words behind.
    end
  end
endmodule // dic_src_model

/* dic_sync2.v */
// Two-flop synchroniser of parameterised width.
`timescale 1ns/1ps
module dic_sync2 #(
  parameter WIDTH = 1
) (
  input wire clk_sys, // System clock.
  input wire rst_n, // Synchronous reset, active low.
  input wire [WIDTH-1:0] async_in, // Level from outside the clock domain.
  output reg [WIDTH-1:0] sync_out // Level after two flip-flops.
);

  reg [WIDTH-1:0] meta_q; // First stage, read only by the second stage.

  // The first stage may go metastable, so nothing but the second stage looks at it.
  always @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      meta_q <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end
    else
    begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule // dic_sync2
